// ### hw/dtm_timer_ctrl.sv
`include "dtm_regs.svh"
// How it works
// RULE1: timer A mode register resets zero, takes bit or byte writes.
// RULE2: timer A enable low clears and halts counter; high lets it count.
// RULE3: timer A clock codes select fx/64, /256, /16, /1024, /4096.
// RULE4: timer A codes 100x and 101x pick timer B match and carrier clock.
// RULE5: mode bits from both registers decode four joint operating modes.
// RULE6: cascaded mode ignores timer A enable; timer B enable rules both.
// RULE7: cascaded mode forces timer A clock to timer B output.
// RULE8: software stops a counter before changing its mode or clock.
// RULE9: software writes zero to timer A mode bits 0 and 6.
// RULE10: timer A extension register holds only bit 0, resets zero.
// RULE11: timer B mode register resets zero with documented field layout.
// RULE12: timer B enable clears/starts timer B, and timer A when cascaded.
// RULE13: timer B clock codes pick fx, 2fx, fx/2, /4, /8, /16.
// RULE14: software sets clock multiply control before using doubled clock.
// RULE15: timer B output enable gates timer B output onto its pin.
// RULE16: discrete mode clears each counter on compare match or overflow.
// RULE17: cascaded match raises only timer B irq, when both halves match.
// RULE18: fixed-zero control bits always read back as zero.
module dtm_timer_ctrl
  import dtm_pkg::*;
(
  input  wire logic                core_clk,          // system clock fx
  input  wire logic                rst_b,             // sync reset, active low
  input  wire logic                fx2_tick,          // doubled-clock tick, async origin
  input  wire dtm_pkg::dtm_addr_type bus_addr,        // cpu address
  input  wire logic                bus_wr,            // byte write strobe
  input  wire logic                bus_bit_wr,        // single-bit write strobe
  input  wire logic          [2:0] bus_bit_sel,       // bit index for bit write
  input  wire dtm_pkg::dtm_byte_type bus_wdata,       // write data (bit 0 for bit write)
  output dtm_pkg::dtm_byte_type    bus_rdata,         // read data
  input  wire dtm_pkg::dtm_byte_type timer_a_compare, // timer A compare value
  input  wire dtm_pkg::dtm_byte_type timer_b_compare, // timer B compare value
  input  wire logic                carrier_clk_tick,  // carrier clock pulse from timer B logic
  output dtm_pkg::dtm_byte_type    timer_a_counter,   // timer A count
  output dtm_pkg::dtm_byte_type    timer_b_counter,   // timer B count
  output logic                     timer_a_match_irq, // timer A match pulse
  output logic                     timer_b_match_irq, // timer B match pulse
  output dtm_pkg::dtm_mode_type    op_mode,           // decoded joint mode
  output logic                     mode_illegal,      // prohibited mode code
  output logic                     timer_b_output_pin,// timer B output value
  output logic                     timer_b_pin_oe_b   // pin enable, low drives
);
  logic [12:0]  tick;
  dtm_byte_type ta_mode_ff;
  dtm_byte_type tb_mode_ff;
  dtm_byte_type ta_ext_ff;
  dtm_byte_type nxt_ta_mode;
  dtm_byte_type nxt_tb_mode;
  dtm_byte_type nxt_ta_ext;
  dtm_byte_type ta_cnt_ff;
  dtm_byte_type tb_cnt_ff;
  dtm_byte_type nxt_ta_cnt;
  dtm_byte_type nxt_tb_cnt;
  logic         fx2_s1_ff;
  logic         fx2_s2_ff;
  logic         tb_out_ff;
  logic         nxt_tb_out;
  logic         ta_irq_ff;
  logic         tb_irq_ff;
  logic         nxt_ta_irq;
  logic         nxt_tb_irq;

  dtm_prescaler u_pre (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tick     (tick)
  );

  // merge a byte or single-bit write into a register image
  function automatic dtm_byte_type wr_merge(input dtm_byte_type cur, input logic byte_wr,
                                            input logic bit_wr, input logic [2:0] sel,
                                            input dtm_byte_type wd, input dtm_byte_type mask);
    dtm_byte_type v;
    v = cur;
    if (byte_wr)
      v = wd;
    else if (bit_wr)
      v[sel] = wd[0];
    return v & mask;
  endfunction

  wire hit_ta_mode = (bus_addr == `DTM_TA_MODE_ADDR);
  wire hit_tb_mode = (bus_addr == `DTM_TB_MODE_ADDR);
  wire hit_ta_ext  = (bus_addr == `DTM_TA_EXT_ADDR);

  assign nxt_ta_mode = wr_merge(ta_mode_ff, bus_wr & hit_ta_mode, bus_bit_wr & hit_ta_mode,
                                bus_bit_sel, bus_wdata, `DTM_TA_MODE_MASK); // [RULE1] [RULE18]
  assign nxt_tb_mode = wr_merge(tb_mode_ff, bus_wr & hit_tb_mode, bus_bit_wr & hit_tb_mode,
                                bus_bit_sel, bus_wdata, `DTM_TB_MODE_MASK); // [RULE11] [RULE18]
  assign nxt_ta_ext  = wr_merge(ta_ext_ff, bus_wr & hit_ta_ext, bus_bit_wr & hit_ta_ext,
                                bus_bit_sel, bus_wdata, `DTM_TA_EXT_MASK); // [RULE10] [RULE18]

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ta_mode_ff <= `DTM_TA_MODE_RESET; // [RULE1]
      tb_mode_ff <= `DTM_TB_MODE_RESET; // [RULE11]
      ta_ext_ff  <= `DTM_TA_EXT_RESET;  // [RULE10]
    end
    else
    begin
      ta_mode_ff <= nxt_ta_mode;
      tb_mode_ff <= nxt_tb_mode;
      ta_ext_ff  <= nxt_ta_ext;
    end
  end

  assign bus_rdata = hit_ta_mode ? ta_mode_ff :
                     hit_tb_mode ? tb_mode_ff :
                     hit_ta_ext  ? ta_ext_ff  : 8'h00; // [RULE18]

  // joint mode decode
  wire [3:0] mode_code = {ta_mode_ff[`DTM_BIT_MODE_HI:`DTM_BIT_MODE_LO],
                          tb_mode_ff[`DTM_BIT_MODE_HI:`DTM_BIT_MODE_LO]};
  assign mode_illegal = !(mode_code == 4'h0 || mode_code == 4'h5 ||
                          mode_code == 4'h3 || mode_code == 4'h2);
  assign op_mode = (mode_code == 4'h5) ? DTM_MODE_CASCADE :
                   (mode_code == 4'h3) ? DTM_MODE_CARRIER :
                   (mode_code == 4'h2) ? DTM_MODE_PULSE   : DTM_MODE_DISCRETE; // [RULE5]
  wire cascade = (op_mode == DTM_MODE_CASCADE);

  wire tb_run = tb_mode_ff[`DTM_BIT_ENABLE];                                    // [RULE12]
  wire ta_run = cascade ? tb_run : ta_mode_ff[`DTM_BIT_ENABLE];                 // [RULE2] [RULE6]

  // doubled clock arrives from outside; synchronise before use
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      fx2_s1_ff <= 1'b0;
      fx2_s2_ff <= 1'b0;
    end
    else
    begin
      fx2_s1_ff <= fx2_tick;
      fx2_s2_ff <= fx2_s1_ff;
    end
  end

  // timer B count clock; 2fx gives an extra step per cycle when the doubled tick is set
  wire [2:0] tb_sel = tb_mode_ff[`DTM_BIT_SEL_HI:`DTM_BIT_SEL_LO];
  wire tb_step2 = (tb_sel == 3'h1) & fx2_s2_ff;
  wire tb_clk_en = (tb_sel == 3'h0) ? tick[0] :
                   (tb_sel == 3'h1) ? tick[0] :
                   (tb_sel == 3'h2) ? tick[1] :
                   (tb_sel == 3'h3) ? tick[2] :
                   (tb_sel == 3'h4) ? tick[3] :
                   (tb_sel == 3'h5) ? tick[4] : 1'b0; // [RULE13]

  wire tb_match = (tb_cnt_ff == timer_b_compare);
  wire ta_match = (ta_cnt_ff == timer_a_compare);
  wire tb_ovf   = (tb_cnt_ff == 8'hff) & tb_clk_en;
  wire tb_event = tb_match | tb_ovf; // timer B output signal feeding cascade

  // timer A count clock
  wire [3:0] ta_sel = {ta_mode_ff[`DTM_BIT_SEL_HI:`DTM_BIT_SEL_LO], ta_ext_ff[`DTM_BIT_EXT]};
  wire ta_sel_clk = (ta_sel[3:1] == 3'h0) ? tick[6]  :
                    (ta_sel[3:1] == 3'h1) ? tick[8]  :
                    (ta_sel[3:1] == 3'h2) ? tick[4]  :
                    (ta_sel == 4'h6)      ? tick[10] :
                    (ta_sel == 4'h7)      ? tick[12] : // [RULE3]
                    (ta_sel[3:1] == 3'h4) ? (tb_match & tb_clk_en) :
                    (ta_sel[3:1] == 3'h5) ? carrier_clk_tick : 1'b0; // [RULE4]
  wire ta_clk_en = cascade ? (tb_event & tb_clk_en) : ta_sel_clk; // [RULE7]

  wire both_match = ta_match & tb_match;
  wire ta_clr = cascade ? (both_match & tb_clk_en) : (ta_match & ta_clk_en);   // [RULE16]
  wire tb_clr = cascade ? (both_match & tb_clk_en) : (tb_match & tb_clk_en);   // [RULE16]

  // stop clears, a clear wins over a step, otherwise step on the count clock
  function automatic dtm_byte_type cnt_next(input logic run, input logic clr, input logic en,
                                            input dtm_byte_type cur, input dtm_byte_type step);
    dtm_byte_type v;
    v = cur;
    if (!run || clr)
      v = 8'h00;
    else if (en)
      v = 8'(cur + step);
    return v;
  endfunction

  assign nxt_tb_cnt = cnt_next(tb_run, tb_clr, tb_clk_en, tb_cnt_ff,
                               tb_step2 ? 8'h02 : 8'h01); // [RULE12] [RULE16]
  assign nxt_ta_cnt = cnt_next(ta_run, ta_clr, ta_clk_en, ta_cnt_ff, 8'h01); // [RULE2] [RULE6]

  assign nxt_tb_out = (!tb_run) ? 1'b0 : (tb_clr ? ~tb_out_ff : tb_out_ff);
  // irq pulses one cycle after the matching tick
  assign nxt_ta_irq = ta_run & ~cascade & ta_match & ta_clk_en;               // [RULE17]
  assign nxt_tb_irq = tb_run & (cascade ? both_match : tb_match) & tb_clk_en; // [RULE17]

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ta_cnt_ff <= 8'h00;
      tb_cnt_ff <= 8'h00;
      tb_out_ff <= 1'b0;
      ta_irq_ff <= 1'b0;
      tb_irq_ff <= 1'b0;
    end
    else
    begin
      ta_cnt_ff <= nxt_ta_cnt;
      tb_cnt_ff <= nxt_tb_cnt;
      tb_out_ff <= nxt_tb_out;
      ta_irq_ff <= nxt_ta_irq; // [RULE17]
      tb_irq_ff <= nxt_tb_irq; // [RULE17]
    end
  end

  assign timer_a_counter    = ta_cnt_ff;
  assign timer_b_counter    = tb_cnt_ff;
  assign timer_a_match_irq  = ta_irq_ff;
  assign timer_b_match_irq  = tb_irq_ff;

  // pin is held low whenever the output is disabled
  wire tb_oe = tb_mode_ff[`DTM_BIT_OUT_EN];
  assign timer_b_output_pin = tb_oe & tb_out_ff;  // [RULE15]
  assign timer_b_pin_oe_b   = ~tb_oe;             // [RULE15]
endmodule

// ### hw/dtm_regs.svh
`ifndef DTM_REGS_SVH
`define DTM_REGS_SVH
`define DTM_TA_MODE_ADDR     16'hff65
`define DTM_TB_MODE_ADDR     16'hff69
`define DTM_TA_EXT_ADDR      16'hff6d
`define DTM_TA_MODE_RESET    8'h00
`define DTM_TB_MODE_RESET    8'h00
`define DTM_TA_EXT_RESET     8'h00
`define DTM_TA_MODE_MASK     8'hbe
`define DTM_TB_MODE_MASK     8'hbf
`define DTM_TA_EXT_MASK      8'h01
`define DTM_BIT_ENABLE       7
`define DTM_BIT_SEL_HI       5
`define DTM_BIT_SEL_LO       3
`define DTM_BIT_MODE_HI      2
`define DTM_BIT_MODE_LO      1
`define DTM_BIT_OUT_EN       0
`define DTM_BIT_EXT          0
`endif

// ### hw/dtm_pkg.sv
package dtm_pkg;
  typedef enum logic [1:0] {
    DTM_MODE_DISCRETE,
    DTM_MODE_CASCADE,
    DTM_MODE_CARRIER,
    DTM_MODE_PULSE
  } dtm_mode_type;
  typedef logic [7:0]  dtm_byte_type;
  typedef logic [15:0] dtm_addr_type;
endpackage

// ### hw/dtm_prescaler.sv
module dtm_prescaler
  import dtm_pkg::*;
(
  input  wire logic        core_clk, // system clock
  input  wire logic        rst_b,    // sync reset, active low
  output logic      [12:0] tick      // one-cycle pulse per power-of-two division
);
  logic [11:0] div_ff;
  logic [11:0] nxt_div;

  assign nxt_div = div_ff + 12'h001;
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      div_ff <= 12'h000;
    else
      div_ff <= nxt_div;
  end

  // tick[k] pulses once every 2^k cycles
  assign tick[0] = 1'b1;
  genvar k;
  generate
    for (k = 1; k < 13; k++)
    begin : g_tick
      assign tick[k] = &div_ff[k-1:0];
    end
  endgenerate
endmodule

// ### sim/dtm_timer_ctrl_props.sv
`include "dtm_regs.svh"
module dtm_timer_ctrl_props
  import dtm_pkg::*;
(
  input wire logic                  core_clk,           // system clock
  input wire logic                  rst_b,              // sync reset, active low
  input wire dtm_pkg::dtm_addr_type bus_addr,           // cpu address
  input wire dtm_pkg::dtm_byte_type bus_rdata,          // read data
  input wire dtm_pkg::dtm_byte_type timer_a_counter,    // timer A count
  input wire dtm_pkg::dtm_byte_type timer_b_counter,    // timer B count
  input wire logic                  timer_a_match_irq,  // timer A match pulse
  input wire dtm_pkg::dtm_mode_type op_mode,            // decoded joint mode
  input wire logic                  timer_b_output_pin, // timer B output value
  input wire logic                  timer_b_pin_oe_b    // pin enable, low drives
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_a_fixed_zero: assert property (bus_addr == `DTM_TA_MODE_ADDR |-> !bus_rdata[6] && !bus_rdata[0])
    else $error("timer a mode fixed bits read nonzero");
  a_ext_fixed_zero: assert property (bus_addr == `DTM_TA_EXT_ADDR |-> bus_rdata[7:1] == 7'h00)
    else $error("extension fixed bits read nonzero");
  a_a_stop_clear: assert property (bus_addr == `DTM_TA_MODE_ADDR && !bus_rdata[7] &&
    op_mode != DTM_MODE_CASCADE |=> timer_a_counter == 8'h00)
    else $error("timer a not cleared while stopped");
  a_b_stop_clear: assert property (bus_addr == `DTM_TB_MODE_ADDR && !bus_rdata[7]
    |=> timer_b_counter == 8'h00)
    else $error("timer b not cleared while stopped");
  a_cascade_a_clear: assert property (bus_addr == `DTM_TB_MODE_ADDR && !bus_rdata[7] &&
    op_mode == DTM_MODE_CASCADE |=> timer_a_counter == 8'h00)
    else $error("cascaded timer a not cleared by timer b stop");
  a_pin_enable_tracks: assert property (bus_addr == `DTM_TB_MODE_ADDR |-> timer_b_pin_oe_b == !bus_rdata[0])
    else $error("pin enable differs from output enable bit");
  a_pin_low_off: assert property (timer_b_pin_oe_b |-> !timer_b_output_pin)
    else $error("pin driven while output disabled");
  a_cascade_no_airq: assert property (op_mode == DTM_MODE_CASCADE &&
    $past(op_mode) == DTM_MODE_CASCADE |-> !timer_a_match_irq)
    else $error("timer a irq raised in cascaded mode");
  a_a_step_clear: assert property (op_mode == DTM_MODE_DISCRETE && $changed(timer_a_counter) |->
    timer_a_counter == $past(timer_a_counter) + 8'h01 || timer_a_counter == 8'h00)
    else $error("timer a count neither stepped nor cleared");
endmodule
bind dtm_timer_ctrl dtm_timer_ctrl_props dtm_timer_ctrl_props_i (.core_clk(core_clk),
  .rst_b(rst_b), .bus_addr(bus_addr), .bus_rdata(bus_rdata), .timer_a_counter(timer_a_counter),
  .timer_b_counter(timer_b_counter), .timer_a_match_irq(timer_a_match_irq), .op_mode(op_mode),
  .timer_b_output_pin(timer_b_output_pin), .timer_b_pin_oe_b(timer_b_pin_oe_b));

// ### sim/dtm_timer_ctrl_test.sv
`include "dtm_regs.svh"
module dtm_timer_ctrl_test
  import dtm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         core_clk = 0, rst_b = 0, fx2_tick = 1, bus_wr = 0, bus_bit_wr = 0;
  logic         carrier_clk_tick = 0, timer_a_match_irq, timer_b_match_irq, mode_illegal;
  logic         timer_b_output_pin, timer_b_pin_oe_b;
  logic [2:0]   bus_bit_sel = 3'h0;
  dtm_addr_type bus_addr = 16'h0000;
  dtm_byte_type bus_wdata = 8'h00, timer_a_compare = 8'hff, timer_b_compare = 8'hff;
  dtm_byte_type bus_rdata, timer_a_counter, timer_b_counter, snap;
  dtm_mode_type op_mode, em;
  int           n_mismatch = 0, total_checks = 0, seed = 9378;
  int           m[3] = '{0, 0, 0};
  int           ad[7] = '{64, 256, 16, 1024, 4096, 4, 8};
  int           na = 0, nb = 0, np = 0;
  logic [2:0]   car_cnt = 3'h0;
  dtm_addr_type ra[3] = '{`DTM_TA_MODE_ADDR, `DTM_TB_MODE_ADDR, `DTM_TA_EXT_ADDR};
  dtm_byte_type mk[3] = '{`DTM_TA_MODE_MASK, `DTM_TB_MODE_MASK, `DTM_TA_EXT_MASK};
  always #2.5 core_clk = ~core_clk;
  // carrier clock stand-in: one pulse every 8 cycles
  always @(posedge core_clk)
  begin
    car_cnt          <= car_cnt + 3'h1;
    carrier_clk_tick <= car_cnt == 3'h7;
  end
  dtm_timer_ctrl dtm_timer_ctrl_i (
    .core_clk           (core_clk),
    .rst_b              (rst_b),
    .fx2_tick           (fx2_tick),
    .bus_addr           (bus_addr),
    .bus_wr             (bus_wr),
    .bus_bit_wr         (bus_bit_wr),
    .bus_bit_sel        (bus_bit_sel),
    .bus_wdata          (bus_wdata),
    .bus_rdata          (bus_rdata),
    .timer_a_compare    (timer_a_compare),
    .timer_b_compare    (timer_b_compare),
    .carrier_clk_tick   (carrier_clk_tick),
    .timer_a_counter    (timer_a_counter),
    .timer_b_counter    (timer_b_counter),
    .timer_a_match_irq  (timer_a_match_irq),
    .timer_b_match_irq  (timer_b_match_irq),
    .op_mode            (op_mode),
    .mode_illegal       (mode_illegal),
    .timer_b_output_pin (timer_b_output_pin),
    .timer_b_pin_oe_b   (timer_b_pin_oe_b)
  );
  task automatic chk(input dtm_byte_type got, input dtm_byte_type exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int r, input dtm_byte_type d, input bit bw, input int b);
    @(posedge core_clk);
    bus_addr <= r < 3 ? ra[r] : 16'hff66;
    {bus_bit_sel, bus_wdata} <= {b[2:0], d};
    {bus_wr, bus_bit_wr} <= bw ? 2'b01 : 2'b10;
    @(posedge core_clk);
    {bus_wr, bus_bit_wr} <= 2'b00;
    if (r < 3)
      m[r] = (bw ? (m[r] & ~(1 << b[2:0])) | (d[0] << b[2:0]) : d) & mk[r];
  endtask
  task automatic rd(input int r);
    @(posedge core_clk);
    bus_addr <= r < 3 ? ra[r] : 16'hff66;
    @(negedge core_clk);
    chk(bus_rdata, r < 3 ? m[r][7:0] : 8'h00);
  endtask
  task automatic meas(input bit b, input int cyc, input dtm_byte_type exp);
    @(negedge core_clk);
    snap = b ? timer_b_counter : timer_a_counter;
    repeat (cyc) @(negedge core_clk);
    chk((b ? timer_b_counter : timer_a_counter) - snap, exp);
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge core_clk);
    n_mismatch++;
    finish_test;
  end
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int r = 0; r < 4; r++) rd(r);
    wr(3, 8'hff, 0, 0);
    rd(3);
    for (int i = 0; i < 24; i++)
    begin
      wr(i % 3, 8'($random(seed)), i > 11, $random(seed));
      rd(i % 3);
    end
    for (int c = 0; c < 16; c++)
    begin
      wr(0, {5'h0, c[3:2], 1'b0}, 0, 0);
      wr(1, {5'h0, c[1:0], 1'b0}, 0, 0);
      em = c == 5 ? DTM_MODE_CASCADE : c == 3 ? DTM_MODE_CARRIER :
           c == 2 ? DTM_MODE_PULSE : DTM_MODE_DISCRETE;
      @(negedge core_clk);
      chk({7'h0, mode_illegal}, {7'h0, !(c inside {0, 2, 3, 5})});
      if (c inside {0, 2, 3, 5}) chk({6'h0, op_mode}, {6'h0, em});
    end
    wr(0, 8'h82, 0, 0);
    wr(1, 8'h02, 0, 0);
    rd(1);
    repeat (300) @(negedge core_clk);
    chk(timer_a_counter, 8'h00);
    wr(1, 8'h83, 0, 0);
    repeat (600) @(negedge core_clk);
    chk(timer_a_counter, 8'h02);
    chk({7'h0, timer_b_pin_oe_b}, 8'h00);
    wr(0, 8'h00, 0, 0);
    for (int c = 0; c < 6; c++)
    begin
      wr(1, 8'h00, 0, 0);
      wr(1, {2'b10, c[2:0], 3'h0}, 0, 0);
      meas(1, 16 << (c < 2 ? 0 : c - 1), c == 1 ? 8'h20 : 8'h10);
    end
    wr(1, 8'h00, 0, 0);
    timer_b_compare <= 8'h03;
    wr(1, 8'h80, 0, 0);
    for (int i = 0; i < 7; i++)
    begin
      wr(0, 8'h00, 0, 0);
      wr(2, {7'h0, i == 4}, 0, 0);
      wr(0, {2'b10, i == 6 ? 3'h5 : i == 5 ? 3'h4 : i > 2 ? 3'h3 : 3'(i), 3'h0}, 0, 0);
      meas(0, 2 * ad[i], 8'h02);
    end
    wr(0, 8'h00, 0, 0);
    wr(1, 8'h00, 0, 0);
    timer_a_compare <= 8'h01;
    wr(0, 8'ha0, 0, 0);
    wr(1, 8'h81, 0, 0);
    repeat (16) @(negedge core_clk);
    repeat (80)
    begin
      @(negedge core_clk);
      na += timer_a_match_irq === 1'b1;
      nb += timer_b_match_irq === 1'b1;
      np += timer_b_output_pin === 1'b1;
    end
    chk(8'(na), 8'h0a);
    chk(8'(nb), 8'h14);
    chk(8'(np), 8'h28);
    finish_test;
  end
endmodule
